// ---- include/pic_pkg.sv ----
/*
 * Shared constants and carriers of the priority interrupt controller:
 * register addresses, reset values, field positions, event codes.
 * Assumes a 32-bit APB byte address and a 125 MHz bus clock.
 */
package pic_pkg;
	localparam logic [31:0] ADDR_PRI_EXT = 32'hfe080000;
	localparam logic [31:0] ADDR_PEND = 32'hfe080020;
	localparam logic [31:0] ADDR_MSK = 32'hfe080040;
	localparam logic [31:0] ADDR_MSK_CLR = 32'hfe080060;
	localparam logic [31:0] ADDR_CTRL = 32'hffd00000;
	localparam logic [31:0] ADDR_IPR_A = 32'hffd00004;
	localparam logic [31:0] ADDR_IPR_B = 32'hffd00008;
	localparam logic [31:0] ADDR_IPR_C = 32'hffd0000c;
	localparam logic [31:0] ADDR_IPR_D = 32'hffd00010;

	localparam logic [15:0] IPR_D_RST = 16'hda74;
	localparam logic [31:0] MSK_RST = 32'h000003ff;

	// Control register bit positions
	localparam int CTRL_NMI_LEVEL = 15;
	localparam int CTRL_NMI_UNBLOCK = 9;
	localparam int CTRL_EDGE_POL = 8;
	localparam int CTRL_IND_MODE = 7;

	localparam int NUM_PER = 20;
	localparam logic [2:0] NMI_HOLD_CYC = 3'h6;
	localparam logic [1:0] IRL_STABLE_SMP = 2'h3;

	localparam logic [4:0] LVL_NMI = 5'h10;
	localparam logic [11:0] EVT_NMI = 12'h1c0;
	localparam logic [11:0] EVT_IRL_BASE = 12'h200;
	localparam logic [11:0] EVT_PER_BASE = 12'h600;
	localparam logic [3:0][11:0] EVT_IND = {12'h360, 12'h300, 12'h2a0, 12'h240};
	localparam logic [3:0] IRL_NONE = 4'hf;

	typedef struct packed {
		logic [3:0] mask_level;  // cpu_mask_level
		logic guard;             // exception_guard_flag
		logic sleep;             // sleep or standby
		logic standby;           // standby: bus sampling uses timekeeper clock
		logic take;              // CPU accepts presented request, one pulse
	} pic_cpu_in_t;

	typedef struct packed {
		logic req;
		logic [4:0] level;
		logic [11:0] code;
	} pic_cpu_out_t;
endpackage

// ---- logic/pic_irl_filter.sv ----
/*
 * Noise filter for the request lines: output follows the input only
 * after the same value was seen on a set number of consecutive samples.
 * Input must already be synchronised to clk.
 */
`timescale 1ns/1ps
module pic_irl_filter #(
	parameter int W = 4
) (
	input wire logic clk,               // bus clock
	input wire logic rst_n,             // async reset, active low
	input wire logic sample_en,         // take a sample this cycle
	input wire logic [W-1:0] din,       // synchronised lines
	output logic [W-1:0] dout           // filtered lines
);
	typedef struct packed {
		logic [W-1:0] last;
		logic [1:0] cnt;
		logic [W-1:0] out;
	} pic_flt_t;

	pic_flt_t st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (sample_en) begin
			st_nxt.last = din;
			if (din != st_r.last) begin
				st_nxt.cnt = 2'h1;
			end else if (st_r.cnt != pic_pkg::IRL_STABLE_SMP) begin
				st_nxt.cnt = st_r.cnt + 2'h1;
			end
			if (st_nxt.cnt == pic_pkg::IRL_STABLE_SMP) begin
				st_nxt.out = din;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '1;
			st_r.cnt <= 2'h0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dout = st_r.out;

	a_flt_three_same: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(st_r.out) |-> $past(sample_en) && $past(st_r.cnt) >= 2'h2
			&& st_r.out == $past(st_r.last))
		else $error("filter output changed before three equal samples");
endmodule

// ---- logic/pic_ctrl.sv ----
/*
 * Priority interrupt controller: nonmaskable edge input, four request
 * lines (encoded or independent), peripheral requests, APB registers,
 * and the request/event code presented to the CPU.
 * Assumes the CPU pulses take for one cycle when it accepts the request.
 */
// Added by the designer: the APB slave port.
// Function
// - Requests rank from level 16 highest down to level 1 lowest.
// - A source at priority level 0 is masked and ignored.
// - Nonmaskable request is level 16, refused only while guard flag set.
// - In sleep or standby the nonmaskable request passes the guard flag.
// - Control bit lets the nonmaskable request pass the guard flag.
// - Nonmaskable input is edge detected, polarity chosen by a control bit.
// - After a polarity write, detection is suppressed up to 6 cycles.
// - A readable bit shows the present nonmaskable pin level.
// - Control register reads 8000 with pin high, 0000 with pin low, after reset.
// - Taking a nonmaskable request leaves the CPU mask level alone.
// - Encoded lines are level sensed; code v means level 15 minus v.
// - Encoded requests are taken only above the CPU mask level.
// - Encoded lines count only after three equal consecutive samples.
// - In standby the filter samples on the timekeeper clock.
// - Independent mode makes the four lines four separate requests.
// - Each peripheral has a 0 to 15 priority in the priority registers.
// - Peripherals share one entry; the event code names the source.
// - A take with no valid request gives event code 0.
// - Equal levels resolve by fixed source order.
// - Peripheral priorities reset to 0, so peripherals start masked.
// - Every source has its own event code.
`timescale 1ns/1ps
module pic_ctrl (
	input wire logic pclk,                        // bus clock, 125 MHz
	input wire logic presetn,                     // async reset, active low
	input wire logic psel,                        // APB select
	input wire logic penable,                     // APB enable
	input wire logic pwrite,                      // APB direction
	input wire logic [31:0] paddr,                // APB byte address
	input wire logic [31:0] pwdata,               // APB write data
	output logic [31:0] prdata,                   // APB read data
	output logic pready,                          // APB ready
	output logic pslverr,                         // APB error
	input wire logic nmi_pin,                     // nonmaskable request pin
	input wire logic [3:0] encoded_level_request, // request lines, active low
	input wire logic rtc_clk,                     // 32.768 kHz timekeeper clock
	input wire logic [pic_pkg::NUM_PER-1:0] per_req, // peripheral levels
	input pic_pkg::pic_cpu_in_t cpu_in,           // CPU state and take
	output pic_pkg::pic_cpu_out_t cpu_out,        // request to the CPU
	output logic [11:0] event_code_register       // code of taken source
);
	typedef struct packed {
		logic edge_pol;
		logic unblock;
		logic ind_mode;
		logic [3:0][15:0] ipr;
		logic [31:0] pri_ext;
		logic [31:0] msk;
		logic [pic_pkg::NUM_PER-1:0] pend;
		logic nmi_s1;
		logic nmi_s2;
		logic nmi_d;
		logic [3:0] irl_s1;
		logic [3:0] irl_s2;
		logic rtc_s1;
		logic rtc_s2;
		logic rtc_d;
		logic nmi_pend;
		logic [2:0] hold;
		logic [11:0] evt;
		logic [31:0] rdata;
		logic err;
		pic_pkg::pic_cpu_out_t out;
	} pic_st_t;

	pic_st_t st_r, st_nxt;
	logic [3:0] irl_flt;
	logic smp_en;
	logic [4:0] best_lvl;
	logic [11:0] best_code;
	logic best_nmi;
	logic win_req;
	logic nmi_edge;
	logic wr_acc;

	function automatic logic [3:0] nib(input logic [15:0] r, input int i);
		return r[i*4 +: 4];
	endfunction

	function automatic logic [3:0] per_prio(input pic_st_t s, input int i);
		if (i < 12) begin
			return nib(s.ipr[i/4], i%4);
		end
		return s.pri_ext[(i-12)*4 +: 4];
	endfunction

	function automatic logic addr_ok(input logic [31:0] a);
		case (a)
			pic_pkg::ADDR_PRI_EXT, pic_pkg::ADDR_PEND, pic_pkg::ADDR_MSK,
			pic_pkg::ADDR_MSK_CLR, pic_pkg::ADDR_CTRL, pic_pkg::ADDR_IPR_A,
			pic_pkg::ADDR_IPR_B, pic_pkg::ADDR_IPR_C, pic_pkg::ADDR_IPR_D: begin
				return 1'b1;
			end
			default: begin
				return 1'b0;
			end
		endcase
	endfunction

	function automatic logic [31:0] rd_mux(input pic_st_t s, input logic [31:0] a);
		case (a)
			pic_pkg::ADDR_PRI_EXT: begin
				return s.pri_ext;
			end
			pic_pkg::ADDR_PEND: begin
				return {{(32-pic_pkg::NUM_PER){1'b0}}, s.pend};
			end
			pic_pkg::ADDR_MSK: begin
				return s.msk;
			end
			pic_pkg::ADDR_CTRL: begin
				return {16'h0000, s.nmi_s2, 5'h00, s.unblock, s.edge_pol,
					s.ind_mode, 7'h00};
			end
			pic_pkg::ADDR_IPR_A: begin
				return {16'h0000, s.ipr[0]};
			end
			pic_pkg::ADDR_IPR_B: begin
				return {16'h0000, s.ipr[1]};
			end
			pic_pkg::ADDR_IPR_C: begin
				return {16'h0000, s.ipr[2]};
			end
			pic_pkg::ADDR_IPR_D: begin
				return {16'h0000, s.ipr[3]};
			end
			default: begin
				return 32'h00000000;
			end
		endcase
	endfunction

	// Standby stops bus-rate sampling; without a running timekeeper clock
	// no samples arrive and the lines cannot wake the device.
	assign smp_en = cpu_in.standby ? (st_r.rtc_s2 & ~st_r.rtc_d) : 1'b1;

	pic_irl_filter #(.W(4)) u_flt (
		.clk(pclk),
		.rst_n(presetn),
		.sample_en(smp_en),
		.din(st_r.irl_s2),
		.dout(irl_flt)
	);

	assign nmi_edge = (st_r.hold == 3'h0) && (st_r.edge_pol ?
		(st_r.nmi_s2 & ~st_r.nmi_d) : (~st_r.nmi_s2 & st_r.nmi_d));
	assign wr_acc = psel & penable & pwrite;

	// Arbitration; a strict compare keeps the earlier source on a tie.
	always_comb begin
		logic [4:0] lv;
		lv = 5'h00;
		best_lvl = 5'h00;
		best_code = 12'h000;
		best_nmi = 1'b0;
		if (st_r.nmi_pend) begin
			best_lvl = pic_pkg::LVL_NMI;
			best_code = pic_pkg::EVT_NMI;
			best_nmi = 1'b1;
		end
		if (!st_r.ind_mode) begin
			lv = {1'b0, 4'hf - irl_flt};
			if (irl_flt != pic_pkg::IRL_NONE && lv > best_lvl) begin
				best_lvl = lv;
				best_code = pic_pkg::EVT_IRL_BASE + {3'h0, irl_flt, 5'h00};
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				lv = {1'b0, nib(st_r.ipr[3], 3-i)};
				if (!irl_flt[i] && lv > best_lvl) begin
					best_lvl = lv;
					best_code = pic_pkg::EVT_IND[i];
				end
			end
		end
		for (int i = 0; i < pic_pkg::NUM_PER; i++) begin
			lv = {1'b0, per_prio(st_r, i)};
			if (st_r.pend[i] && !st_r.msk[i] && lv > best_lvl) begin
				best_lvl = lv;
				best_code = pic_pkg::EVT_PER_BASE + {2'h0, 5'(i), 5'h00};
			end
		end
		if (best_nmi) begin
			win_req = !cpu_in.guard || cpu_in.sleep || st_r.unblock;
		end else begin
			win_req = best_lvl != 5'h00 && !cpu_in.guard
				&& best_lvl > {1'b0, cpu_in.mask_level};
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.nmi_s1 = nmi_pin;
		st_nxt.nmi_s2 = st_r.nmi_s1;
		st_nxt.nmi_d = st_r.nmi_s2;
		st_nxt.irl_s1 = encoded_level_request;
		st_nxt.irl_s2 = st_r.irl_s1;
		st_nxt.rtc_s1 = rtc_clk;
		st_nxt.rtc_s2 = st_r.rtc_s1;
		st_nxt.rtc_d = st_r.rtc_s2;
		st_nxt.pend = per_req;
		st_nxt.out.req = win_req;
		st_nxt.out.level = win_req ? best_lvl : 5'h00;
		st_nxt.out.code = win_req ? best_code : 12'h000;
		if (st_r.hold != 3'h0) begin
			st_nxt.hold = st_r.hold - 3'h1;
		end
		// Only the nonmaskable pending flag is dropped; the mask level is
		// left for the CPU, which the controller never drives.
		if (cpu_in.take) begin
			st_nxt.evt = win_req ? best_code : 12'h000;
			if (win_req && best_nmi) begin
				st_nxt.nmi_pend = 1'b0;
			end
		end
		if (nmi_edge) begin
			st_nxt.nmi_pend = 1'b1;
		end
		if (psel && !penable) begin
			st_nxt.err = !addr_ok(paddr);
			st_nxt.rdata = rd_mux(st_r, paddr);
		end
		if (wr_acc) begin
			case (paddr)
				pic_pkg::ADDR_PRI_EXT: begin
					st_nxt.pri_ext = pwdata;
				end
				pic_pkg::ADDR_MSK: begin
					st_nxt.msk = st_r.msk | pwdata;
				end
				pic_pkg::ADDR_MSK_CLR: begin
					st_nxt.msk = st_r.msk & ~pwdata;
				end
				pic_pkg::ADDR_CTRL: begin
					st_nxt.unblock = pwdata[pic_pkg::CTRL_NMI_UNBLOCK];
					st_nxt.edge_pol = pwdata[pic_pkg::CTRL_EDGE_POL];
					st_nxt.ind_mode = pwdata[pic_pkg::CTRL_IND_MODE];
					if (pwdata[pic_pkg::CTRL_EDGE_POL] != st_r.edge_pol) begin
						st_nxt.hold = pic_pkg::NMI_HOLD_CYC;
					end
				end
				pic_pkg::ADDR_IPR_A: begin
					st_nxt.ipr[0] = pwdata[15:0];
				end
				pic_pkg::ADDR_IPR_B: begin
					st_nxt.ipr[1] = pwdata[15:0];
				end
				pic_pkg::ADDR_IPR_C: begin
					st_nxt.ipr[2] = pwdata[15:0];
				end
				pic_pkg::ADDR_IPR_D: begin
					st_nxt.ipr[3] = pwdata[15:0];
				end
				default: begin
					st_nxt.err = st_r.err;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.ipr[3] <= pic_pkg::IPR_D_RST;
			st_r.msk <= pic_pkg::MSK_RST;
			st_r.irl_s1 <= pic_pkg::IRL_NONE;
			st_r.irl_s2 <= pic_pkg::IRL_NONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.rdata;
	assign pready = 1'b1;
	assign pslverr = psel & penable & st_r.err;
	assign cpu_out = st_r.out;
	assign event_code_register = st_r.evt;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_nmi_edge_sets: assert property (
		nmi_edge |=> st_r.nmi_pend)
		else $error("detected edge did not set pending flag");
	a_pol_write_hold: assert property (
		wr_acc && paddr == pic_pkg::ADDR_CTRL
			&& pwdata[pic_pkg::CTRL_EDGE_POL] != st_r.edge_pol
		|=> st_r.hold == 3'h6 ##1 !nmi_edge [*5])
		else $error("edge detection not held off after polarity write");
	a_nmi_guarded: assert property (
		best_nmi && cpu_in.guard && !cpu_in.sleep && !st_r.unblock |=> !cpu_out.req)
		else $error("nonmaskable request passed a set guard flag");
	a_nmi_sleep_pass: assert property (
		best_nmi && cpu_in.sleep |=> cpu_out.req && cpu_out.level == 5'h10)
		else $error("nonmaskable request refused in sleep");
	a_nmi_unblock: assert property (
		best_nmi && st_r.unblock |=> cpu_out.code == 12'h1c0)
		else $error("unblock setting ignored");
	a_req_above_mask: assert property (
		cpu_out.req && cpu_out.level != 5'h10
		|-> cpu_out.level > {1'b0, $past(cpu_in.mask_level)} && !$past(cpu_in.guard))
		else $error("request presented at or below mask level");
	a_level_nonzero: assert property (
		cpu_out.req |-> cpu_out.level != 5'h00)
		else $error("level zero source presented");
	a_spurious_zero: assert property (
		cpu_in.take && !win_req |=> event_code_register == 12'h000)
		else $error("spurious take gave nonzero code");
	a_take_code: assert property (
		cpu_in.take && win_req |=> event_code_register == $past(best_code))
		else $error("taken source code not recorded");
	a_pin_level: assert property (
		psel && !penable && paddr == pic_pkg::ADDR_CTRL |=> prdata[15] == $past(st_r.nmi_s2))
		else $error("pin level bit wrong");
	a_encoded_level: assert property (
		!st_r.ind_mode && !st_r.nmi_pend && irl_flt != 4'hf
		|-> best_lvl >= {1'b0, 4'hf - irl_flt})
		else $error("encoded level not ranked");

	c_nmi_taken: cover property (cpu_in.take && win_req && best_nmi);
	c_irl_taken: cover property (cpu_in.take && win_req && best_code[11:8] == 4'h2);
	c_per_taken: cover property (cpu_in.take && win_req && best_code[11:8] == 4'h6);
	c_spurious: cover property (cpu_in.take && !win_req);
endmodule

// ---- dv/pic_cpu_model.sv ----
/*
 Model of the CPU exception side: holds mask level, guard, sleep and standby state,
 and accepts a presented request once per arm, promptly or after a delay.
 Assumes the bench changes its controls right after rising edges.
*/
`timescale 1ns/1ps
module pic_cpu_model (
	input wire logic pclk, // bus clock
	input wire logic presetn, // reset, active low
	input pic_pkg::pic_cpu_out_t cpu_out, // request from controller
	input wire logic [3:0] mask_level, // current mask level
	input wire logic guard, // exception guard flag
	input wire logic sleep, // sleep mode
	input wire logic arm, // allow one take
	input wire logic blind, // take even with no request
	input wire logic slow, // wait three cycles before taking
	input wire logic standby, // standby mode
	output pic_pkg::pic_cpu_in_t cpu_in // state and take to controller
);
	logic armed;
	logic take;
	logic [1:0] cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed <= 1'b0;
			take <= 1'b0;
			cnt <= 2'h0;
		end else begin
			take <= 1'b0;
			if (arm) begin
				armed <= 1'b1;
			end else if (armed && (cpu_out.req || blind)) begin
				// Mask level is never touched on a take
				if (cnt == {slow, slow}) begin
					take <= 1'b1;
					armed <= 1'b0;
					cnt <= 2'h0;
				end else begin
					cnt <= cnt + 2'h1;
				end
			end
		end
	end

	// Standby comes from the bench so the timekeeper sampling path is exercised
	assign cpu_in = {mask_level, guard, sleep, standby, take};
endmodule

// ---- dv/priority_interrupt_controller_tb_top.sv ----
/*
 Self-checking bench of the interrupt controller: APB register traffic,
 peripheral, encoded, independent and nonmaskable requests.
 Assumes the CPU model takes a request once per arm.
*/
`timescale 1ns/1ps
module priority_interrupt_controller_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, nmi_pin;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] lines, mask_level;
	logic [19:0] per_req;
	logic guard, sleep, standby, arm, blind, slow, take_d, rtc_clk, rtc_run;
	logic [11:0] event_code_register;
	logic [3:0] p;
	logic [3:0] v;
	pic_pkg::pic_cpu_in_t cpu_in;
	pic_pkg::pic_cpu_out_t cpu_out;
	logic [11:0] exp_q[$];
	int error_cnt, compares, takes, cyc;

	pic_ctrl u_pic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin),
		.encoded_level_request(lines), .rtc_clk(rtc_clk), .per_req(per_req),
		.cpu_in(cpu_in), .cpu_out(cpu_out), .event_code_register(event_code_register));
	pic_cpu_model u_pic_cpu_model (.pclk(pclk), .presetn(presetn), .cpu_out(cpu_out),
		.mask_level(mask_level), .guard(guard), .sleep(sleep), .arm(arm),
		.blind(blind), .slow(slow), .standby(standby), .cpu_in(cpu_in));

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// Timekeeper stand-in: toggles only while enabled, so it can be stopped
	always @(posedge pclk) begin
		if (rtc_run)
			rtc_clk <= ~rtc_clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		if (exp_q.size() != 0)
			error_cnt++;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic bad);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		if (!w)
			chk("prdata", d, prdata);
		chk("pslverr", 32'(bad), 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic quiet();
		repeat (12) @(posedge pclk);
		chk("req", 32'h0, 32'(cpu_out.req));
	endtask

	task automatic expect_take(input logic [11:0] code, input logic bl);
		int n;
		exp_q.push_back(code);
		n = takes;
		@(posedge pclk);
		arm <= 1'b1;
		blind <= bl;
		slow <= 1'($urandom);
		@(posedge pclk);
		arm <= 1'b0;
		for (int i = 0; i < 200 && takes == n; i++)
			@(posedge pclk);
		repeat (2) @(posedge pclk);
	endtask

	// Event code lands one edge after the take pulse
	always @(posedge pclk) begin
		take_d <= cpu_in.take;
		if (take_d === 1'b1) begin
			takes++;
			chk("event_code", 32'(exp_q.pop_front()), 32'(event_code_register));
		end
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		void'($urandom(32'h37ba));
		{presetn, psel, penable, pwrite, nmi_pin, guard, sleep, arm, blind, slow} = '0;
		{standby, rtc_clk, rtc_run} = '0;
		{paddr, pwdata, per_req, mask_level} = '0;
		lines = 4'hf;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, pic_pkg::ADDR_IPR_D, {16'h0, pic_pkg::IPR_D_RST}, 1'b0);
		apb(1'b0, pic_pkg::ADDR_IPR_A, 32'h0, 1'b0);
		apb(1'b0, pic_pkg::ADDR_PRI_EXT, 32'h0, 1'b0);
		apb(1'b0, pic_pkg::ADDR_MSK, pic_pkg::MSK_RST, 1'b0);
		apb(1'b0, pic_pkg::ADDR_CTRL, 32'h0, 1'b0);
		apb(1'b0, 32'hffd00020, 32'h0, 1'b1);
		guard <= 1'b1;
		apb(1'b1, pic_pkg::ADDR_MSK_CLR, 32'h3ff, 1'b0);
		p = 4'(1 + $urandom % 15);
		apb(1'b1, pic_pkg::ADDR_IPR_A, {16'h0, p, p, 8'h0}, 1'b0);
		apb(1'b1, pic_pkg::ADDR_PRI_EXT, 32'hf, 1'b0);
		apb(1'b0, pic_pkg::ADDR_PRI_EXT, 32'hf, 1'b0);
		guard <= 1'b0;
		per_req <= 20'h00002;
		quiet();
		mask_level <= p;
		per_req <= 20'h0000e;
		quiet();
		mask_level <= p - 4'h1;
		apb(1'b1, pic_pkg::ADDR_MSK, 32'hc, 1'b0);
		quiet();
		apb(1'b1, pic_pkg::ADDR_MSK_CLR, 32'hc, 1'b0);
		expect_take(12'h640, 1'b0);
		per_req <= 20'h01004;
		expect_take((p == 4'hf) ? 12'h640 : 12'h780, 1'b0);
		per_req <= '0;
		mask_level <= 4'h0;
		repeat (3) begin
			v = 4'($urandom % 15);
			// Level is held until taken, then released
			lines <= v;
			expect_take(pic_pkg::EVT_IRL_BASE + 12'(v) * 12'h20, 1'b0);
			lines <= 4'hf;
			repeat (10) @(posedge pclk);
		end
		// Two-cycle glitch gives only two equal samples
		lines <= 4'h0;
		repeat (2) @(posedge pclk);
		lines <= 4'hf;
		quiet();
		standby <= 1'b1;
		lines <= 4'h5;
		quiet();
		rtc_run <= 1'b1;
		expect_take(pic_pkg::EVT_IRL_BASE + 12'h0a0, 1'b0);
		{rtc_run, standby} <= 2'b00;
		lines <= 4'hf;
		repeat (10) @(posedge pclk);
		apb(1'b1, pic_pkg::ADDR_CTRL, 32'h80, 1'b0);
		lines <= 4'he;
		expect_take(12'h240, 1'b0);
		lines <= 4'hf;
		apb(1'b1, pic_pkg::ADDR_CTRL, 32'h100, 1'b0);
		repeat (8) @(posedge pclk);
		guard <= 1'b1;
		nmi_pin <= 1'b1;
		quiet();
		apb(1'b0, pic_pkg::ADDR_CTRL, 32'h8100, 1'b0);
		sleep <= 1'b1;
		expect_take(pic_pkg::EVT_NMI, 1'b0);
		sleep <= 1'b0;
		apb(1'b1, pic_pkg::ADDR_CTRL, 32'h200, 1'b0);
		repeat (8) @(posedge pclk);
		nmi_pin <= 1'b0;
		expect_take(pic_pkg::EVT_NMI, 1'b0);
		guard <= 1'b0;
		// Second reset with the pin high; bit 15 follows the pin through the sync
		nmi_pin <= 1'b1;
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, pic_pkg::ADDR_CTRL, 32'h8000, 1'b0);
		apb(1'b0, pic_pkg::ADDR_IPR_D, {16'h0, pic_pkg::IPR_D_RST}, 1'b0);
		repeat (10) @(posedge pclk);
		expect_take(12'h0, 1'b1);
		stop_test();
	end
endmodule
